/* File: verilog/dtc_pkg.sv */
// package: register map, field layout and types of the detect/channel config bank
package dtc_pkg;

	localparam int DTC_ADDR_W = 4;
	localparam int DTC_DATA_W = 16;

	localparam logic [3:0] DTC_OFS_TH_HI  = 4'h7;
	localparam logic [3:0] DTC_OFS_TH_LO  = 4'h8;
	localparam logic [3:0] DTC_OFS_CH0CFG = 4'h9;

	localparam logic [15:0] DTC_RST_VAL = 16'h0000;

	localparam int DTC_TH_LO_POS    = 8;
	localparam int DTC_COEFF_POS    = 0;
	localparam int DTC_COEFF_W      = 4;
	localparam int DTC_PHASE_POS    = 6;
	localparam int DTC_PHASE_W      = 10;
	localparam int DTC_DCOFF_POS    = 2;
	localparam int DTC_INSEL_POS    = 0;
	localparam int DTC_INSEL_W      = 2;

	localparam logic [3:0] DTC_COEFF_BYPASS = 4'h0;

	typedef enum logic [1:0] {
		DTC_IN_NORMAL,
		DTC_IN_SHORTED,
		DTC_IN_TEST_POS,
		DTC_IN_TEST_NEG
	} dtc_insel_t;

	typedef struct packed {
		logic [23:0] detectThreshold;
		logic [3:0]  offsetRemovalCoeff;
		logic        filterBypassAll;
		logic [9:0]  chan0PhaseTrim;
		logic        chan0OffsetRemovalOn;
		dtc_insel_t  chan0InputSelect;
	} dtc_cfg_t;

endpackage : dtc_pkg

/* File: verilog/dtc_reg_cell.sv */
// file: one 16-bit register cell with a writable-bit mask
`timescale 1ns/100ps
module dtc_reg_cell
	import dtc_pkg::*;
#(
	parameter logic [15:0] WR_MASK = 16'hffff
)(
	input  wire logic        clk,
	input  wire logic        rstSyncN,
	input  wire logic        wrEn,
	input  wire logic [15:0] wrData,
	output logic      [15:0] value
);

	logic [15:0] value_q;

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			value_q <= DTC_RST_VAL;
		else if (wrEn)
			value_q <= wrData & WR_MASK;
	end

	assign value = value_q;

endmodule : dtc_reg_cell

/* File: verilog/dtc_regs.sv */
// file: top of the detect threshold and channel 0 configuration register bank
// What this block does
// RULE_01 - register 7h is read/write, holds threshold upper 16 bits, resets zero
// RULE_02 - register 8h bits 15:8 hold threshold low byte, read/write, reset zero
// RULE_03 - register 8h bits 3:0 pick offset-removal coefficient 1/2^(n+1)
// RULE_04 - coefficient code zero bypasses offset removal on all channels
// RULE_05 - register 8h bits 7:4 read zero; software writes zeros
// RULE_06 - register 9h bits 15:6 hold signed 10-bit channel 0 phase delay
// RULE_07 - register 9h bits 5:3 read-only, read zero; software writes zeros
// RULE_08 - register 9h bit 2 forces channel 0 offset removal off
// RULE_09 - register 9h bits 1:0 select channel 0 input source
// RULE_10 - all three registers are 16 bits and reset to 0000h
// RULE_11 - threshold is upper register as bits 23:8, low byte as 7:0
`timescale 1ns/100ps
module dtc_regs
	import dtc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [DTC_ADDR_W-1:0] regAddr,
	input  wire logic [DTC_DATA_W-1:0] regWrData,
	input  wire logic                  regWrStb,
	input  wire logic                  regRdStb,
	output logic      [DTC_DATA_W-1:0] regRdData,
	output dtc_cfg_t                   cfgOut
);

	// ********************************
	// reset release
	// ********************************
	logic rstMeta_q;
	logic rstSyncN;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta_q <= 1'b0;
			rstSyncN  <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstSyncN  <= rstMeta_q;
		end
	end

	// ********************************
	// registers
	// ********************************
	localparam logic [15:0] MASK_TH_HI  = 16'hffff;
	localparam logic [15:0] MASK_TH_LO  = 16'hff0f;
	localparam logic [15:0] MASK_CH0CFG = 16'hffc7;

	logic [15:0] thHi;
	logic [15:0] thLo;
	logic [15:0] ch0Cfg;

	function automatic logic hitAddr(input logic [3:0] a, input logic [3:0] ofs);
		hitAddr = (a == ofs);
	endfunction : hitAddr

	dtc_reg_cell #(.WR_MASK(MASK_TH_HI)) uThHi ( // RULE_01 RULE_10
		.clk      (clk),
		.rstSyncN (rstSyncN),
		.wrEn     (regWrStb && hitAddr(regAddr, DTC_OFS_TH_HI)),
		.wrData   (regWrData),
		.value    (thHi)
	);

	dtc_reg_cell #(.WR_MASK(MASK_TH_LO)) uThLo ( // RULE_02 RULE_03 RULE_05 RULE_10
		.clk      (clk),
		.rstSyncN (rstSyncN),
		.wrEn     (regWrStb && hitAddr(regAddr, DTC_OFS_TH_LO)),
		.wrData   (regWrData),
		.value    (thLo)
	);

	dtc_reg_cell #(.WR_MASK(MASK_CH0CFG)) uCh0Cfg ( // RULE_06 RULE_07 RULE_10
		.clk      (clk),
		.rstSyncN (rstSyncN),
		.wrEn     (regWrStb && hitAddr(regAddr, DTC_OFS_CH0CFG)),
		.wrData   (regWrData),
		.value    (ch0Cfg)
	);

	// ********************************
	// read port
	// ********************************
	logic [15:0] regRdData_d;
	logic [15:0] regRdData_q;

	always_comb
	begin
		regRdData_d = 16'h0000;
		if (regRdStb)
		begin
			if (hitAddr(regAddr, DTC_OFS_TH_HI))
				regRdData_d = thHi;
			else if (hitAddr(regAddr, DTC_OFS_TH_LO))
				regRdData_d = thLo; // RULE_05
			else if (hitAddr(regAddr, DTC_OFS_CH0CFG))
				regRdData_d = ch0Cfg; // RULE_07
		end
	end

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			regRdData_q <= 16'h0000;
		else
			regRdData_q <= regRdData_d;
	end

	assign regRdData = regRdData_q;

	// ********************************
	// configuration outputs
	// ********************************
	logic [3:0] coeff;
	logic       bypassAll;

	assign coeff     = thLo[DTC_COEFF_POS +: DTC_COEFF_W]; // RULE_03
	assign bypassAll = (coeff == DTC_COEFF_BYPASS); // RULE_04

	always_comb
	begin
		cfgOut.detectThreshold      = {thHi, thLo[DTC_TH_LO_POS +: 8]}; // RULE_11
		cfgOut.offsetRemovalCoeff   = coeff; // RULE_03
		cfgOut.filterBypassAll      = bypassAll; // RULE_04
		cfgOut.chan0PhaseTrim       = ch0Cfg[DTC_PHASE_POS +: DTC_PHASE_W]; // RULE_06
		cfgOut.chan0OffsetRemovalOn = !bypassAll && !ch0Cfg[DTC_DCOFF_POS]; // RULE_08
		cfgOut.chan0InputSelect     = dtc_insel_t'(ch0Cfg[DTC_INSEL_POS +: DTC_INSEL_W]); // RULE_09
	end

endmodule : dtc_regs

/* File: tb/dtc_regs_asserts.sv */
// checker: port assertions of the register bank
`timescale 1ns/100ps
module dtc_regs_asserts
	import dtc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWrStb,
	input wire logic        regRdStb,
	input wire logic [15:0] regRdData,
	input wire dtc_cfg_t    cfgOut
);
	// ****
	// checks
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RD7: assert property (regRdStb && regAddr == 7 |=>
		regRdData == cfgOut.detectThreshold[23:8]) else $error("bad read 7");
	AST_RD8: assert property (regRdStb && regAddr == 8 |=> regRdData ==
		{cfgOut.detectThreshold[7:0], 4'h0, cfgOut.offsetRemovalCoeff}) else $error("bad read 8");
	AST_RD9: assert property (regRdStb && regAddr == 9 |=> regRdData[5:3] == 3'h0 &&
		regRdData[15:6] == cfgOut.chan0PhaseTrim && regRdData[1:0] == cfgOut.chan0InputSelect)
		else $error("bad read 9");
	AST_UNMAP: assert property (regRdStb && (regAddr < 7 || regAddr > 9) |=>
		regRdData == 16'h0) else $error("unmapped read");
	AST_BYPASS: assert property (cfgOut.filterBypassAll ==
		(cfgOut.offsetRemovalCoeff == 4'h0)) else $error("bad bypass");
	AST_CH0ON: assert property (regRdStb && regAddr == 9 |=>
		cfgOut.chan0OffsetRemovalOn == (!cfgOut.filterBypassAll && !regRdData[2]))
		else $error("bad ch0 filter");
	AST_WR7: assert property (regWrStb && regAddr == 7 |=>
		cfgOut.detectThreshold[23:8] == $past(regWrData)) else $error("bad write 7");
	AST_WR8: assert property (regWrStb && regAddr == 8 |=>
		cfgOut.detectThreshold[7:0] == $past(regWrData[15:8])
		&& cfgOut.offsetRemovalCoeff == $past(regWrData[3:0])) else $error("bad write 8");
	cover property (regWrStb ##1 regRdStb);
	cover property (regRdStb && regAddr == 9);
	cover property (regWrStb && regAddr == 8);
endmodule : dtc_regs_asserts

/* File: tb/tb_dtc_regs.sv */
// testbench: register bank with queued read checks
`timescale 1ns/100ps
module tb_dtc_regs;
	import dtc_pkg::*;
	logic        clk = 0, rst_n = 0, regWrStb = 0, regRdStb = 0, rdPend = 0;
	logic [3:0]  regAddr = 0;
	logic [15:0] regWrData = 0, regRdData, d, m [16], q [$];
	logic [31:0] seed = 32'he039;
	dtc_cfg_t    cfgOut, ce, cq [$];
	int          failures = 0, comparisons = 0;
	always #2 clk = ~clk;
	dtc_regs dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .cfgOut(cfgOut));
	function logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	function dtc_cfg_t expCfg();
		expCfg.detectThreshold      = {m[7], m[8][15:8]};
		expCfg.offsetRemovalCoeff   = m[8][3:0];
		expCfg.filterBypassAll      = (m[8][3:0] == 4'h0);
		expCfg.chan0PhaseTrim       = m[9][15:6];
		expCfg.chan0OffsetRemovalOn = (m[8][3:0] != 4'h0) && !m[9][2];
		expCfg.chan0InputSelect     = dtc_insel_t'(m[9][1:0]);
	endfunction : expCfg
	task chk(string n, logic [23:0] s, logic [23:0] e);
		comparisons++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task op(logic w, logic r, logic [3:0] a, logic [15:0] v);
		@(posedge clk);
		regWrStb <= w;
		regRdStb <= r;
		regAddr <= a;
		regWrData <= v;
		if (w) m[a] = v & (a == 7 ? 16'hffff : a == 8 ? 16'hff0f : a == 9 ? 16'hffc7 : 16'h0);
		if (r) q.push_back(m[a]);
		if (r) cq.push_back(expCfg());
	endtask : op
	task complete_run();
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	always @(posedge clk)
	begin
		if (rdPend)
		begin
			ce = cq.pop_front();
			chk("regRdData", regRdData, q.pop_front());
			chk("coeff", cfgOut.offsetRemovalCoeff, ce.offsetRemovalCoeff);
			chk("bypass", cfgOut.filterBypassAll, ce.filterBypassAll);
			chk("ch0on", cfgOut.chan0OffsetRemovalOn, ce.chan0OffsetRemovalOn);
			chk("thr", cfgOut.detectThreshold, ce.detectThreshold);
			chk("phase", cfgOut.chan0PhaseTrim, ce.chan0PhaseTrim);
			chk("source", cfgOut.chan0InputSelect, ce.chan0InputSelect);
		end
		rdPend <= regRdStb;
	end
	initial
	begin
		foreach (m[i]) m[i] = 16'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 16; a++) op(0, 1, a[3:0], 16'h0);
		for (int i = 0; i < 256; i++)
		begin
			d = rnd();
			d[3:0] = i[7:4];
			op(1, 0, i[3:0], d);
			op(0, 1, i[3:0], 16'h0);
		end
		op(0, 0, 4'h0, 16'h0);
		repeat (2) @(posedge clk);
		chk("threshold", cfgOut.detectThreshold, {m[7], m[8][15:8]});
		chk("trim", cfgOut.chan0PhaseTrim, m[9][15:6]);
		chk("insel", cfgOut.chan0InputSelect, m[9][1:0]);
		complete_run();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule : tb_dtc_regs
bind dtc_regs dtc_regs_asserts chk_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
	.regRdData(regRdData), .cfgOut(cfgOut));
